// *** verilog/pdr_ram.sv ***
// pseudo dual-port ram block: one 16384-bit array, write port and read port
`timescale 1ns/1ps
module pdr_ram (
	// clock and global reset
	input wire logic clk,
	input wire logic rst,
	// configuration
	input wire pdr_pkg::pdr_cfg_t cfg,
	// global clocks and local reset
	input wire logic global_clock_0,
	input wire logic global_clock_1,
	input wire logic global_clock_2,
	input wire logic global_clock_3,
	input wire logic local_reset,
	// write port
	input wire logic write_clock,
	input wire logic write_port_clock_enable,
	input wire logic write_enable,
	input wire logic write_chip_select,
	input wire logic [13:0] write_address,
	input wire logic [31:0] write_data,
	// read port
	input wire logic read_clock,
	input wire logic read_port_clock_enable,
	input wire logic [13:0] read_address,
	output logic [31:0] read_data
);
	import pdr_pkg::*;

	function automatic logic sel_clk(input logic [2:0] s, input logic ded,
			input logic [3:0] g, input logic inv);
		logic v;
		v = ded;
		case (s)
			PDR_CK_G0: v = g[0];
			PDR_CK_G1: v = g[1];
			PDR_CK_G2: v = g[2];
			PDR_CK_G3: v = g[3];
			default: v = ded;
		endcase
		return v ^ inv;
	endfunction

	function automatic logic sel_ce(input logic [1:0] s, input logic ded,
			input logic [3:0] g, input logic inv);
		logic v;
		v = ded;
		case (s)
			PDR_CE_G1: v = g[1];
			PDR_CE_G2: v = g[2];
			default: v = ded;
		endcase
		return v ^ inv;
	endfunction

	function automatic logic [31:0] width_mask(input logic [2:0] w);
		logic [31:0] m;
		m = 32'hffffffff;
		case (w)
			PDR_W1: m = 32'h00000001;
			PDR_W2: m = 32'h00000003;
			PDR_W4: m = 32'h0000000f;
			PDR_W8: m = 32'h000000ff;
			PDR_W16: m = 32'h0000ffff;
			default: m = 32'hffffffff;
		endcase
		return m;
	endfunction

	function automatic logic [13:0] bit_addr(input logic [13:0] a, input logic [2:0] w);
		logic [13:0] b;
		b = a;
		case (w)
			PDR_W1: b = a;
			PDR_W2: b = {a[12:0], 1'h0};
			PDR_W4: b = {a[11:0], 2'h0};
			PDR_W8: b = {a[10:0], 3'h0};
			PDR_W16: b = {a[9:0], 4'h0};
			default: b = {a[8:0], 5'h0};
		endcase
		return b;
	endfunction

	pdr_pins_t pins_raw;
	pdr_pins_t sync1_r;
	pdr_pins_t sync2_r;
	pdr_pins_t s;
	logic lrst_s;
	logic wck_now;
	logic rck_now;
	logic wck_prev_r;
	logic rck_prev_r;
	logic wedge;
	logic redge;
	logic wce_now;
	logic rce_now;
	logic [13:0] waddr_r;
	logic [31:0] wdata_r;
	logic wen_r;
	logic wcs_r;
	logic wr_go_r;
	logic [13:0] raddr_r;
	logic [13:0] raddr_eff;
	logic [13:0] wbit;
	logic [13:0] rbit;
	logic [31:0] rword;
	logic [31:0] rd_val;
	logic [31:0] read_data_r;
	// array starts cleared so that reads of unwritten words are defined
	logic [PDR_WORD_W-1:0] mem [0:(PDR_MEM_BITS/PDR_WORD_W)-1] = '{default: '0};

	assign pins_raw = {cfg, global_clock_3, global_clock_2, global_clock_1, global_clock_0,
		local_reset, write_clock, write_port_clock_enable, write_enable, write_chip_select,
		write_address, write_data, read_clock, read_port_clock_enable, read_address};

	// two-stage pin synchroniser
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= pins_raw;
			sync2_r <= sync1_r;
		end
	end
	assign s = sync2_r;

	assign lrst_s = s.lrst ^ s.cfg.rst_inv;

	// clock and enable selection with edge detection
	assign wck_now = sel_clk(s.cfg.wclk_sel, s.wclk, s.gclk, s.cfg.wclk_inv);
	assign rck_now = sel_clk(s.cfg.rclk_sel, s.rclk, s.gclk, s.cfg.rclk_inv);
	assign wce_now = sel_ce(s.cfg.wce_sel, s.wce, s.gclk, s.cfg.wce_inv);
	assign rce_now = sel_ce(s.cfg.rce_sel, s.rce, s.gclk, s.cfg.rce_inv);
	assign wedge = wck_now & ~wck_prev_r;
	assign redge = rck_now & ~rck_prev_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wck_prev_r <= 1'b0;
			rck_prev_r <= 1'b0;
		end else begin
			wck_prev_r <= wck_now;
			rck_prev_r <= rck_now;
		end
	end

	// write-side capture registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			waddr_r <= PDR_ADDR_RST;
			wdata_r <= PDR_DATA_RST;
			wen_r <= 1'b0;
			wcs_r <= 1'b0;
			wr_go_r <= 1'b0;
		end else if (lrst_s) begin
			waddr_r <= PDR_ADDR_RST;
			wdata_r <= PDR_DATA_RST;
			wen_r <= 1'b0;
			wcs_r <= 1'b0;
			wr_go_r <= 1'b0;
		end else begin
			wr_go_r <= wedge & wce_now & s.wen & s.wcs;
			if (wedge && wce_now) begin
				waddr_r <= s.waddr;
				wdata_r <= s.wdata;
				wen_r <= s.wen;
				wcs_r <= s.wcs;
			end
		end
	end

	// array write, bit-granular for narrow widths
	assign wbit = bit_addr(waddr_r, s.cfg.width);
	always_ff @(posedge clk) begin
		if (wr_go_r && wen_r && wcs_r) begin
			mem[wbit[13:5]] <= (mem[wbit[13:5]] & ~(width_mask(s.cfg.width) << wbit[4:0]))
				| ((wdata_r & width_mask(s.cfg.width)) << wbit[4:0]);
		end
	end

	// read side
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			raddr_r <= PDR_ADDR_RST;
		end else if (lrst_s) begin
			raddr_r <= PDR_ADDR_RST;
		end else if (redge && rce_now) begin
			raddr_r <= s.raddr;
		end
	end

	assign raddr_eff = s.cfg.raddr_reg ? raddr_r : s.raddr;
	assign rbit = bit_addr(raddr_eff, s.cfg.width);
	assign rword = mem[rbit[13:5]];
	assign rd_val = (rword >> rbit[4:0]) & width_mask(s.cfg.width);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			read_data_r <= PDR_DATA_RST;
		end else if (lrst_s) begin
			read_data_r <= PDR_DATA_RST;
		end else if (!s.cfg.rdata_reg) begin
			read_data_r <= rd_val;
		end else if (redge && rce_now) begin
			read_data_r <= rd_val;
		end
	end
	assign read_data = read_data_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_wr_capture: assert property ((wedge && wce_now && !lrst_s) |=>
		(waddr_r == $past(s.waddr)) && (wdata_r == $past(s.wdata)))
		else $error("write inputs not captured on enabled write edge");
	chk_wr_hold: assert property ((!(wedge && wce_now) && !lrst_s) |=> $stable(waddr_r))
		else $error("write address changed without enabled write edge");
	chk_write_gate: assert property (wr_go_r |-> $past(s.wen && s.wcs && wce_now))
		else $error("memory write without enable and chip select");
	chk_word_write: assert property ((wr_go_r && s.cfg.width == PDR_W32) |=>
		mem[$past(wbit[13:5])] == $past(wdata_r))
		else $error("full-width write did not land in the array");
	chk_rdata_hold: assert property ((s.cfg.rdata_reg && !(redge && rce_now) && !lrst_s)
		|=> $stable(read_data_r))
		else $error("registered read data moved without read edge");
	chk_rd_follow: assert property ((!rst && !s.cfg.rdata_reg && !lrst_s) |=>
		read_data_r == $past(rd_val))
		else $error("unregistered read data does not follow address");
	chk_local_reset: assert property (lrst_s |=>
		(waddr_r == PDR_ADDR_RST) && (read_data_r == PDR_DATA_RST) && !wr_go_r)
		else $error("local reset did not clear both sides");
	chk_wclk_source: assert property ((s.cfg.wclk_sel == PDR_CK_DED && !s.cfg.wclk_inv
		&& $stable(s.cfg)) |-> (wedge == (s.wclk && !$past(s.wclk))))
		else $error("write edge does not follow dedicated write clock");
	chk_rclk_source: assert property ((s.cfg.rclk_sel == PDR_CK_G0 && s.cfg.rclk_inv
		&& $stable(s.cfg)) |-> (redge == (!s.gclk[0] && $past(s.gclk[0]))))
		else $error("read edge does not follow inverted global clock 0");
	chk_narrow_read: assert property (($past(s.cfg.width) == PDR_W1
		&& !$past(s.cfg.rdata_reg)) |-> read_data_r[31:1] == 31'h0)
		else $error("one-bit read returned upper bits");
endmodule // pdr_ram

// *** verilog/pdr_pkg.sv ***
// shared constants and types for the pseudo dual-port ram block
package pdr_pkg;
	localparam int PDR_MEM_BITS = 16384;
	localparam int PDR_WORD_W = 32;
	localparam int PDR_ADDR_W = 14;
	localparam int PDR_IDX_W = 9;
	localparam int PDR_OFF_W = 5;
	// width codes: data width is 1 << code
	localparam logic [2:0] PDR_W1 = 3'h0;
	localparam logic [2:0] PDR_W2 = 3'h1;
	localparam logic [2:0] PDR_W4 = 3'h2;
	localparam logic [2:0] PDR_W8 = 3'h3;
	localparam logic [2:0] PDR_W16 = 3'h4;
	localparam logic [2:0] PDR_W32 = 3'h5;
	// clock source codes: dedicated input, then global clocks 0..3
	localparam logic [2:0] PDR_CK_DED = 3'h0;
	localparam logic [2:0] PDR_CK_G0 = 3'h1;
	localparam logic [2:0] PDR_CK_G1 = 3'h2;
	localparam logic [2:0] PDR_CK_G2 = 3'h3;
	localparam logic [2:0] PDR_CK_G3 = 3'h4;
	// clock enable source codes
	localparam logic [1:0] PDR_CE_DED = 2'h0;
	localparam logic [1:0] PDR_CE_G1 = 2'h1;
	localparam logic [1:0] PDR_CE_G2 = 2'h2;
	localparam logic [31:0] PDR_DATA_RST = 32'h0;
	localparam logic [13:0] PDR_ADDR_RST = 14'h0;

	typedef struct packed {
		logic [2:0] wclk_sel;
		logic wclk_inv;
		logic [1:0] wce_sel;
		logic wce_inv;
		logic [2:0] rclk_sel;
		logic rclk_inv;
		logic [1:0] rce_sel;
		logic rce_inv;
		logic rst_inv;
		logic [2:0] width;
		logic raddr_reg;
		logic rdata_reg;
	} pdr_cfg_t;

	typedef struct packed {
		pdr_cfg_t cfg;
		logic [3:0] gclk;
		logic lrst;
		logic wclk;
		logic wce;
		logic wen;
		logic wcs;
		logic [13:0] waddr;
		logic [31:0] wdata;
		logic rclk;
		logic rce;
		logic [13:0] raddr;
	} pdr_pins_t;
endpackage

// *** bench/pdr_user.sv ***
// user logic model driving the write and read ports of the ram block
`timescale 1ns/1ps
module pdr_user (
	// clock
	input wire logic clk,
	// sources: write clock, write enable, read clock, read enable, global clocks 0..3
	output logic [7:0] src,
	// write port
	output logic write_enable,
	output logic write_chip_select,
	output logic [13:0] write_address,
	output logic [31:0] write_data,
	// read port
	output logic [13:0] read_address
);
	initial begin
		src = 8'h0;
		write_enable = 1'b0;
		write_chip_select = 1'b0;
		write_address = 14'h0;
		write_data = 32'h0;
		read_address = 14'h0;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge clk);
	endtask
	// all sources low so that a later pulse gives one clean edge
	task automatic idle();
		src <= 8'h0;
		hold(3);
	endtask
	task automatic level(input int b, input logic v);
		src[b] <= v;
		hold(1);
	endtask
	// one pulse: one active edge whether the source is inverted or not
	task automatic pulse(input int b);
		src[b] <= 1'b1;
		hold(3);
		src[b] <= 1'b0;
		hold(3);
	endtask
	task automatic ra(input int a);
		read_address <= 14'(a);
		hold(4);
	endtask
	// address, data and strobes stay put over the whole pulse
	task automatic wr(input int b, input int a, input logic [31:0] d, input logic we, input logic cs);
		write_address <= 14'(a);
		write_data <= d;
		write_enable <= we;
		write_chip_select <= cs;
		hold(1);
		pulse(b);
		write_enable <= 1'b0;
		write_chip_select <= 1'b0;
		write_data <= ~d;
		hold(1);
	endtask
endmodule // pdr_user

// *** bench/tb_pdr_ram.sv ***
// self-checking bench for the pseudo dual-port ram block
`timescale 1ns/1ps
module tb_pdr_ram;
	import pdr_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic local_reset = 1'b0;
	pdr_cfg_t cfg = '0;
	logic [7:0] src;
	logic write_enable;
	logic write_chip_select;
	logic [13:0] write_address;
	logic [31:0] write_data;
	logic [13:0] read_address;
	logic [31:0] read_data;
	logic [16383:0] mem = '0;
	logic [31:0] d;
	int a;
	int r;
	int rb = 2;
	int err_count = 0;
	int num_checks = 0;
	always #4 clk = ~clk;
	pdr_user u_pdr_user (.clk(clk), .src(src), .write_enable(write_enable),
		.write_chip_select(write_chip_select), .write_address(write_address),
		.write_data(write_data), .read_address(read_address));
	pdr_ram u_pdr_ram (.clk(clk), .rst(rst), .cfg(cfg), .global_clock_0(src[4]),
		.global_clock_1(src[5]), .global_clock_2(src[6]), .global_clock_3(src[7]),
		.local_reset(local_reset), .write_clock(src[0]), .write_port_clock_enable(src[1]),
		.write_enable(write_enable), .write_chip_select(write_chip_select),
		.write_address(write_address), .write_data(write_data), .read_clock(src[2]),
		.read_port_clock_enable(src[3]), .read_address(read_address), .read_data(read_data));
	task automatic mw(input int a, input logic [31:0] d, input int w);
		for (int i = 0; i < (1 << w); i++) begin
			mem[(a << w) + i] = d[i];
		end
	endtask
	function automatic logic [31:0] exp_rd(input int a, input int w);
		logic [31:0] v;
		v = '0;
		for (int i = 0; i < (1 << w); i++) begin
			v[i] = mem[(a << w) + i];
		end
		return v;
	endfunction
	task automatic chk(input logic [31:0] e);
		num_checks++;
		if (read_data !== e) begin
			err_count++;
			$display("wrong value at %0t: read_data %h expected %h", $time, read_data, e);
		end
	endtask
	// set the address, give two read edges, then compare
	task automatic rd(input int a);
		u_pdr_user.ra(a);
		u_pdr_user.pulse(rb);
		u_pdr_user.pulse(rb);
		u_pdr_user.hold(2);
		chk(exp_rd(a, int'(cfg.width)));
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		summarize();
	end
	initial begin
		void'($urandom(32'he613));
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		cfg.width <= PDR_W32;
		u_pdr_user.hold(4);
		// write clock and enable sources, good and refused writes
		for (int i = 0; i < 8; i++) begin
			r = $urandom;
			d = $urandom;
			// enable source never shares a pin with the clock source
			a = ((i + 1) % 3 == 0) ? 1 : 4 + (i + 1) % 3;
			cfg.wclk_sel <= 3'(i % 5);
			cfg.wce_sel <= 2'((i + 1) % 3);
			cfg.wclk_inv <= r[0];
			cfg.wce_inv <= r[1];
			u_pdr_user.idle();
			u_pdr_user.level(a, 1'b1 ^ r[1]);
			u_pdr_user.wr((i % 5 == 0) ? 0 : 3 + i % 5, i, d, 1'b1, 1'b1);
			mw(i, d, 5);
			u_pdr_user.level(a, (i % 3 != 0) ^ r[1]);
			u_pdr_user.wr((i % 5 == 0) ? 0 : 3 + i % 5, i, ~d, i % 3 != 1, i % 3 != 2);
			rd(i);
		end
		cfg.wclk_sel <= PDR_CK_DED;
		cfg.wce_sel <= PDR_CE_DED;
		cfg.wclk_inv <= 1'b0;
		cfg.wce_inv <= 1'b0;
		// every width, read back at that width and as a whole word
		for (int w = 0; w < 6; w++) begin
			cfg.width <= 3'(w);
			u_pdr_user.idle();
			u_pdr_user.level(1, 1'b1);
			a = $urandom % (256 >> w);
			d = $urandom;
			u_pdr_user.wr(0, a, d, 1'b1, 1'b1);
			mw(a, d, w);
			rd(a);
			cfg.width <= PDR_W32;
			u_pdr_user.hold(3);
			rd((a << w) >> 5);
		end
		// read clock and enable sources in all four register modes
		for (int i = 0; i < 5; i++) begin
			r = $urandom;
			rb = (i == 0) ? 2 : 3 + i;
			cfg.rclk_sel <= 3'(i);
			cfg.rce_sel <= 2'((i + 1) % 3);
			cfg.rclk_inv <= r[0];
			cfg.rce_inv <= r[1];
			cfg.raddr_reg <= i[0];
			cfg.rdata_reg <= i[1];
			u_pdr_user.idle();
			a = ((i + 1) % 3 == 0) ? 3 : 4 + (i + 1) % 3;
			u_pdr_user.level(a, 1'b1 ^ r[1]);
			rd(i);
			if (i % 4 != 0) begin
				u_pdr_user.ra(i + 1);
				u_pdr_user.level(a, r[1]);
				u_pdr_user.pulse(rb);
				u_pdr_user.pulse(rb);
				chk(exp_rd(i, 5));
			end
		end
		// local reset in both polarities, then global reset; memory survives all
		r = $urandom;
		for (int j = 0; j < 2; j++) begin
			cfg.rst_inv <= r[0] ^ j[0];
			local_reset <= r[0] ^ j[0];
			u_pdr_user.hold(4);
			local_reset <= ~(r[0] ^ j[0]);
			u_pdr_user.hold(6);
			chk(32'h0);
			local_reset <= r[0] ^ j[0];
			rd(3 + j);
		end
		rst <= 1'b1;
		u_pdr_user.hold(2);
		chk(32'h0);
		rst <= 1'b0;
		u_pdr_user.hold(4);
		rd(5);
		summarize();
	end
endmodule // tb_pdr_ram
